// >>> dv/ulw_lin_node.sv
`timescale 1ns/1ps
// ****
// lin node: drives rxd, decodes txd
// ****
module ulw_lin_node (
  input wire logic clk_sys,
  input wire logic bit_tick,
  input wire logic send,
  input wire logic [7:0] send_char,
  output logic rxd_pin,
  input wire logic txd_pin,
  output logic [7:0] got_char,
  output logic [7:0] got_n
);
  logic pend_ff = 1'b0;
  logic [9:0] out_ff = '1;
  logic [3:0] out_n_ff = '0;
  logic [8:0] in_ff = '0;
  logic [3:0] in_n_ff = '0;
  logic [7:0] char_ff = '0;
  logic [7:0] cnt_ff = '0;
  // recessive bus is pulled high, so the shifter refills with ones
  assign rxd_pin = out_ff[0];
  assign got_char = char_ff;
  assign got_n = cnt_ff;
  always_ff @(posedge clk_sys) begin
    if (send) begin
      pend_ff <= 1'b1;
    end else if (bit_tick && pend_ff && out_n_ff == 4'h0) begin
      pend_ff <= 1'b0;
      out_ff <= {1'b1, send_char, 1'b0};
      out_n_ff <= 4'hA;
    end else if (bit_tick && out_n_ff != 4'h0) begin
      out_ff <= {1'b1, out_ff[9:1]};
      out_n_ff <= out_n_ff - 4'h1;
    end
  end
  // sample txd once per bit, lsb first
  always_ff @(posedge clk_sys) begin
    if (bit_tick && in_n_ff == 4'h0 && !txd_pin) begin
      in_n_ff <= 4'h9;
    end else if (bit_tick && in_n_ff != 4'h0) begin
      in_ff <= {txd_pin, in_ff[8:1]};
      in_n_ff <= in_n_ff - 4'h1;
      if (in_n_ff == 4'h1) begin
        char_ff <= in_ff[8:1];
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule

// >>> dv/ulw_top_assertions.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module ulw_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic rxd_pin,
  input wire logic txd_pin,
  input wire logic dma_tx_req,
  input wire logic dma_rx_req
);
  logic wp_ff;
  logic [1:0] chm_ff;
  logic prot;
  logic ctl_wr;
  assign prot = reg_addr inside {8'h04, 8'h20, 8'h24, 8'h28, 8'h40, 8'h4C, 8'h50};
  assign ctl_wr = reg_wr && reg_addr == 8'h00;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wp_ff <= 1'b0;
    end else if (reg_wr && reg_addr == 8'hE4 && reg_wdata[31:8] == ulw_pkg::WP_KEY) begin
      wp_ff <= reg_wdata[0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chm_ff <= 2'h0;
    end else if (reg_wr && reg_addr == 8'h04 && !wp_ff) begin
      chm_ff <= reg_wdata[15:14];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_blocked;
    wp_ff && reg_wr && prot;
  endsequence
  sequence s_wp_rd;
    reg_rd && reg_addr == 8'hE8;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0) reset |=> txd_pin)
    else $error("transmit pin not idle after reset");
  a_wp_report: assert property (s_blocked ##2 s_wp_rd |=> reg_rdata[0] && reg_rdata[15:8] == $past(reg_addr, 3))
    else $error("blocked write not reported");
  a_wp_clear: assert property (s_wp_rd ##2 s_wp_rd |=> !reg_rdata[0])
    else $error("violation flag survived a read");
  a_rx_clear: assert property (reg_rd && reg_addr == 8'h18 |=> !dma_rx_req)
    else $error("receive request not cleared");
  a_echo_follow: assert property ((chm_ff[0] && $stable(rxd_pin)) [*8] |-> txd_pin == rxd_pin)
    else $error("transmit pin does not follow receive pin");
  a_local_high: assert property ((chm_ff == 2'h2) [*3] |-> txd_pin)
    else $error("transmit pin low in local loop");
  a_wake_start: assert property (ctl_wr && reg_wdata[21] && chm_ff == 2'h0 && dma_tx_req |-> ##[1:20] !txd_pin)
    else $error("wake character did not start");
  a_tc_clear: assert property (ctl_wr && reg_wdata[8] && !reg_wdata[21] ##2 reg_rd && reg_addr == 8'h14
    |=> !reg_rdata[15])
    else $error("transfer complete not cleared");
endmodule
bind ulw_top ulw_checker u_checker (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
  .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));

// >>> dv/ulw_top_test.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module ulw_top_test;
  typedef struct {logic [31:0] lm; logic [7:0] ch;} ulw_row_t;
  ulw_row_t rows [2] = '{'{32'h0000_0000, ulw_pkg::WAKE_CHAR_V20}, '{32'h0000_0020, ulw_pkg::WAKE_CHAR_V13}};
  logic [7:0] pa [7] = '{8'h04, 8'h20, 8'h24, 8'h28, 8'h40, 8'h4C, 8'h50};
  logic [31:0] cm [2] = '{32'h0000_4000, 32'h0000_C000};
  logic clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, bit_tick = 0, master_node = 0, send = 0;
  logic [7:0] reg_addr = '0, send_char = '0, got_char, got_n, n;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic txd_pin, rxd_pin, dma_tx_req, dma_rx_req;
  int bad_count = 0, n_compared = 0, cyc = 0;
  ulw_top dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_tick(bit_tick), .master_node(master_node), .rxd_pin(rxd_pin),
    .txd_pin(txd_pin), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
  ulw_lin_node node (.clk_sys(clk_sys), .bit_tick(bit_tick), .send(send), .send_char(send_char),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .got_char(got_char), .got_n(got_n));
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    bit_tick <= (cyc % 8 == 7);
    if (cyc == 12000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    chk(reg_rdata & m, e, nm);
  endtask
  task automatic tx(input logic [7:0] c);
    send_char <= c;
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
  endtask
  task automatic wait_char(input logic [7:0] n0);
    for (int i = 0; i < 300 && got_n == n0; i++) @(posedge clk_sys);
    chk(got_n, n0 + 8'h01, "char count");
  endtask
  task automatic dma(input logic [7:0] c);
    for (int i = 0; i < 300 && dma_tx_req !== 1'b1; i++) @(posedge clk_sys);
    chk(dma_tx_req, 1'b1, "tx request");
    wr(8'h1C, {24'h00_0000, c});
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rdc(8'h04, 32'h0000_C000, 32'h0000_0000, "channel mode");
    rdc(8'h2C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    wr(8'hE4, {ulw_pkg::WP_KEY, 8'h01});
    foreach (pa[i]) begin
      wr(pa[i], 32'h0000_0055);
      rdc(8'hE8, 32'h0000_FF01, {16'h0000, pa[i], 8'h01}, "violation");
      rdc(8'hE8, 32'h0000_0001, 32'h0000_0000, "violation clear");
    end
    rdc(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, "baud kept");
    wr(8'hE4, {ulw_pkg::WP_KEY, 8'h00});
    $display("protection done");
    foreach (rows[i]) begin
      wr(8'h54, rows[i].lm);
      n = got_n;
      wr(8'h00, 32'h0020_0000);
      wait_char(n);
      chk(got_char, rows[i].ch, "wake char");
      repeat (24) @(posedge clk_sys);
      rdc(8'h14, 32'h0000_8000, 32'h0000_8000, "complete set");
      wr(8'h00, 32'h0000_0100);
      rdc(8'h14, 32'h0000_8000, 32'h0000_0000, "complete clear");
    end
    $display("wake done");
    foreach (cm[i]) begin
      wr(8'h04, cm[i]);
      n = got_n;
      tx(8'h5A);
      wait_char(n);
      chk(got_char, 8'h5A, "looped char");
    end
    wr(8'h04, 32'h0000_8000);
    n = got_n;
    wr(8'h00, 32'h0020_0000);
    tx(8'h33);
    repeat (120) @(posedge clk_sys);
    chk(got_n, n, "quiet line");
    wr(8'h04, 32'h0000_0000);
    $display("modes done");
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    tx(8'h2B);
    repeat (120) @(posedge clk_sys);
    rdc(8'h58, 32'h0000_00FF, 32'h0000_002B, "slave id");
    chk(dma_rx_req, 1'b0, "id kept from dma");
    tx(8'hA5);
    for (int i = 0; i < 300 && dma_rx_req !== 1'b1; i++) @(posedge clk_sys);
    rdc(8'h18, 32'h0000_00FF, 32'h0000_00A5, "data byte");
    wr(8'h24, 32'h0000_0006);
    wr(8'h00, 32'h0000_0800);
    repeat (80) @(posedge clk_sys);
    rdc(8'h14, 32'h0000_0100, 32'h0000_0000, "armed idle");
    wr(8'h00, 32'h0000_8000);
    rdc(8'h14, 32'h0000_0100, 32'h0000_0000, "early timeout");
    repeat (64) @(posedge clk_sys);
    rdc(8'h14, 32'h0000_0100, 32'h0000_0100, "timeout set");
    wr(8'h00, 32'h0000_0800);
    rdc(8'h14, 32'h0000_0100, 32'h0000_0000, "armed clear");
    tx(8'h3C);
    repeat (160) @(posedge clk_sys);
    rdc(8'h14, 32'h0000_0100, 32'h0000_0100, "after char");
    wr(8'h24, 32'h0000_0000);
    wr(8'h00, 32'h0000_0800);
    wr(8'h00, 32'h0000_8000);
    repeat (80) @(posedge clk_sys);
    rdc(8'h14, 32'h0000_0100, 32'h0000_0000, "disabled");
    $display("slave done");
    master_node <= 1'b1;
    wr(8'h54, 32'h0002_0000);
    dma(8'h25);
    dma(8'h03);
    rdc(8'h54, 32'h0002_FFFF, 32'h0002_0325, "config bytes");
    dma(8'h1A);
    dma(8'h77);
    for (int i = 0; i < 600 && got_char !== 8'h77; i++) @(posedge clk_sys);
    chk(got_char, 8'h77, "response data");
    rdc(8'h58, 32'h0000_00FF, 32'h0000_001A, "identifier");
    $display("master done");
    summarize();
  end
endmodule

// >>> include/ulw_pkg.sv
package ulw_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_CHAN_STATUS = 8'h14;
  localparam logic [7:0] ADDR_RX_HOLD = 8'h18;
  localparam logic [7:0] ADDR_TX_HOLD = 8'h1C;
  localparam logic [7:0] ADDR_BAUD = 8'h20;
  localparam logic [7:0] ADDR_IDLE_WAIT = 8'h24;
  localparam logic [7:0] ADDR_TIMEGUARD = 8'h28;
  localparam logic [7:0] ADDR_CLK_RATIO = 8'h40;
  localparam logic [7:0] ADDR_IR_FILTER = 8'h4C;
  localparam logic [7:0] ADDR_MANCHESTER = 8'h50;
  localparam logic [7:0] ADDR_LIN_MODE = 8'h54;
  localparam logic [7:0] ADDR_LIN_ID = 8'h58;
  localparam logic [7:0] ADDR_WP_MODE = 8'hE4;
  localparam logic [7:0] ADDR_WP_STATUS = 8'hE8;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CR_STATUS_RESET = 8;
  localparam int CR_ARM_WAIT = 11;
  localparam int CR_RESTART_WAIT = 15;
  localparam int CR_WAKE_REQUEST = 21;
  localparam int MR_CHMODE_LSB = 14;
  localparam int LM_WAKE_TYPE = 5;
  localparam int LM_DMA_CFG = 17;
  localparam int LM_DLC_LSB = 8;
  localparam int SR_TIMEOUT = 8;
  localparam int SR_TXRDY = 1;
  localparam int SR_RXRDY = 0;
  localparam int SR_LIN_TC = 15;
  localparam int WP_SRC_LSB = 8;

  // ************************************************************
  // values
  // ************************************************************
  localparam logic [7:0] WAKE_CHAR_V20 = 8'hF0;
  localparam logic [7:0] WAKE_CHAR_V13 = 8'h80;
  localparam logic [31:0] MAN_RESET = 32'h3001_1004;
  localparam logic [31:0] FIDI_RESET = 32'h0000_0174;
  localparam logic [23:0] WP_KEY = 24'h55_5341;
  localparam int IDLE_WAIT_WIDTH = 17;
  localparam int CHAR_BITS = 10;

  typedef enum logic [1:0] {
    ULW_CH_NORMAL,
    ULW_CH_ECHO,
    ULW_CH_LOCAL_LOOP,
    ULW_CH_REMOTE_LOOP
  } ulw_chmode_t;
endpackage

// >>> verilog/ulw_bit_shift.sv
`timescale 1ns/1ps
// ************************************************************
// 8n1 character engine, lsb first, one bit per bit_tick
// ************************************************************
module ulw_bit_shift (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic bit_tick,
  input wire logic tx_enable,
  input wire logic tx_start,
  input wire logic [7:0] tx_char,
  output logic tx_busy,
  output logic tx_line,
  input wire logic rx_enable,
  input wire logic rx_line,
  output logic rx_valid,
  output logic [7:0] rx_char
);
  logic [9:0] tx_shift_ff;
  logic [3:0] tx_cnt_ff;
  logic [8:0] rx_shift_ff;
  logic [3:0] rx_cnt_ff;

  assign tx_busy = (tx_cnt_ff != 4'h0);

  always_ff @(posedge clk_sys) begin
    if (reset || !tx_enable) begin
      tx_shift_ff <= 10'h3FF;
      tx_cnt_ff <= 4'h0;
    end else if (tx_start && !tx_busy) begin
      tx_shift_ff <= {1'b1, tx_char, 1'b0};
      tx_cnt_ff <= 4'(ulw_pkg::CHAR_BITS);
    end else if (bit_tick && tx_busy) begin
      tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
      tx_cnt_ff <= tx_cnt_ff - 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_line <= 1'b1;
    end else begin
      tx_line <= tx_busy ? tx_shift_ff[0] : 1'b1;
    end
  end

  // samples one point per bit; start detected on low line when idle
  always_ff @(posedge clk_sys) begin
    if (reset || !rx_enable) begin
      rx_shift_ff <= 9'h000;
      rx_cnt_ff <= 4'h0;
      rx_valid <= 1'b0;
      rx_char <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (bit_tick) begin
        if (rx_cnt_ff == 4'h0) begin
          if (!rx_line) begin
            rx_cnt_ff <= 4'h9;
          end
        end else begin
          rx_shift_ff <= {rx_line, rx_shift_ff[8:1]};
          rx_cnt_ff <= rx_cnt_ff - 4'h1;
          if (rx_cnt_ff == 4'h1) begin
            rx_valid <= 1'b1;
            rx_char <= rx_shift_ff[8:1];
          end
        end
      end
    end
  end
endmodule

// >>> verilog/ulw_top.sv
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
// Operation
// - master dma config: two bytes via holding
// - publish: id and data via holding register
// - subscribe: only response data to dma
// - lin 2.0 wake sends 0xF0
// - lin 1.3 wake sends 0x80
// - wake type bit selects character
// - wake command; complete flag until reset or status reset command
// - slave idle timeout raises status flag
// - zero timeout value disables timeout
// - 17-bit counter, per bit, reload, flag
// - arm command stops counter until character
// - restart command reloads and counts now
// - arm command clears flag, cancels period
// - normal: pins to receiver and transmitter
// - echo: rx pin forwarded to tx pin
// - local loop: tx to rx, pin high
// - remote loop: rx pin to tx pin
// - protected write blocked, violation recorded
// - seven configuration registers are protected
// - status read clears violation flag
module ulw_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic bit_tick,
  input wire logic master_node,
  input wire logic rxd_pin,
  output logic txd_pin,
  output logic dma_tx_req,
  output logic dma_rx_req
);
  // ************************************************************
  // pin synchroniser
  // ************************************************************
  logic [2:0] rxd_sync_ff;
  logic rxd_ff;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxd_sync_ff <= 3'b111;
      rxd_ff <= 1'b1;
    end else begin
      rxd_sync_ff <= {rxd_sync_ff[1:0], rxd_pin};
      if (rxd_sync_ff[1] == rxd_sync_ff[2]) begin
        rxd_ff <= rxd_sync_ff[2];
      end
    end
  end

  // ************************************************************
  // register decode
  // ************************************************************
  function automatic logic is_protected(input logic [7:0] addr);
    is_protected = (addr == ulw_pkg::ADDR_MODE) || (addr == ulw_pkg::ADDR_BAUD) ||
                   (addr == ulw_pkg::ADDR_IDLE_WAIT) || (addr == ulw_pkg::ADDR_TIMEGUARD) ||
                   (addr == ulw_pkg::ADDR_CLK_RATIO) || (addr == ulw_pkg::ADDR_IR_FILTER) ||
                   (addr == ulw_pkg::ADDR_MANCHESTER);
  endfunction

  logic write_protect_enable_ff;
  logic write_violation_flag_ff;
  logic [7:0] write_violation_source_ff;
  logic wr_ok;
  logic cr_wr;

  assign wr_ok = reg_wr && !(write_protect_enable_ff && is_protected(reg_addr));
  assign cr_wr = reg_wr && (reg_addr == ulw_pkg::ADDR_CONTROL);

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [31:0] mode_reg_ff;
  logic [31:0] baud_reg_ff;
  logic [16:0] idle_wait_reload_value_ff;
  logic [31:0] timeguard_reg_ff;
  logic [31:0] ratio_reg_ff;
  logic [31:0] irfilter_reg_ff;
  logic [31:0] manchester_reg_ff;
  logic [31:0] lin_mode_reg_ff;
  logic [7:0] lin_identifier_reg_ff;
  ulw_pkg::ulw_chmode_t chmode;
  logic dma_config_buffer_mode;
  logic wake_request_type;

  assign chmode = ulw_pkg::ulw_chmode_t'(mode_reg_ff[ulw_pkg::MR_CHMODE_LSB +: 2]);
  assign dma_config_buffer_mode = lin_mode_reg_ff[ulw_pkg::LM_DMA_CFG];
  assign wake_request_type = lin_mode_reg_ff[ulw_pkg::LM_WAKE_TYPE];

  // dma config byte pairing state
  logic cfg_phase_ff;
  logic id_pending_ff;
  // after the identifier, holding bytes are response data until lin mode is rewritten
  logic resp_phase_ff;
  logic thr_wr;
  logic rx_valid;
  logic [7:0] rx_char;
  logic id_wait_ff;
  logic timeout_flag_ff;

  assign thr_wr = reg_wr && (reg_addr == ulw_pkg::ADDR_TX_HOLD);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_reg_ff <= '0;
      baud_reg_ff <= '0;
      idle_wait_reload_value_ff <= '0;
      timeguard_reg_ff <= '0;
      ratio_reg_ff <= ulw_pkg::FIDI_RESET;
      irfilter_reg_ff <= '0;
      manchester_reg_ff <= ulw_pkg::MAN_RESET;
    end else if (wr_ok) begin
      case (reg_addr)
        ulw_pkg::ADDR_MODE: mode_reg_ff <= reg_wdata;
        ulw_pkg::ADDR_BAUD: baud_reg_ff <= reg_wdata;
        ulw_pkg::ADDR_IDLE_WAIT: idle_wait_reload_value_ff <= reg_wdata[16:0];
        ulw_pkg::ADDR_TIMEGUARD: timeguard_reg_ff <= reg_wdata;
        ulw_pkg::ADDR_CLK_RATIO: ratio_reg_ff <= reg_wdata;
        ulw_pkg::ADDR_IR_FILTER: irfilter_reg_ff <= reg_wdata;
        ulw_pkg::ADDR_MANCHESTER: manchester_reg_ff <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // lin mode: direct write, or two holding-register bytes in master config-buffer mode
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lin_mode_reg_ff <= '0;
      lin_identifier_reg_ff <= '0;
      cfg_phase_ff <= 1'b0;
      id_pending_ff <= 1'b0;
      resp_phase_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ulw_pkg::ADDR_LIN_MODE) begin
        lin_mode_reg_ff <= reg_wdata;
        cfg_phase_ff <= 1'b0;
        resp_phase_ff <= 1'b0;
      end else if (reg_wr && reg_addr == ulw_pkg::ADDR_LIN_ID && master_node) begin
        lin_identifier_reg_ff <= reg_wdata[7:0];
      end else if (thr_wr && master_node && dma_config_buffer_mode && !id_pending_ff && !resp_phase_ff) begin
        if (!cfg_phase_ff) begin
          lin_mode_reg_ff[7:0] <= reg_wdata[7:0];
          cfg_phase_ff <= 1'b1;
        end else begin
          lin_mode_reg_ff[ulw_pkg::LM_DLC_LSB +: 8] <= reg_wdata[7:0];
          cfg_phase_ff <= 1'b0;
          id_pending_ff <= 1'b1;
        end
      end else if (thr_wr && id_pending_ff) begin
        lin_identifier_reg_ff <= reg_wdata[7:0];
        id_pending_ff <= 1'b0;
        resp_phase_ff <= 1'b1;
      end
      if (rx_valid && !master_node && id_wait_ff) begin
        lin_identifier_reg_ff <= rx_char;
      end
    end
  end

  // ************************************************************
  // transmit path: wake-up and holding register
  // ************************************************************
  logic tx_busy;
  logic tx_line;
  logic tx_start;
  logic [7:0] tx_char;
  logic wake_active_ff;
  logic wake_pending_ff;
  logic lin_transfer_complete_ff;
  logic [7:0] thr_data_ff;
  logic thr_full_ff;
  logic tx_enable;
  logic rx_enable;
  logic data_thr_wr;

  assign tx_enable = (chmode != ulw_pkg::ULW_CH_REMOTE_LOOP);
  assign rx_enable = (chmode != ulw_pkg::ULW_CH_REMOTE_LOOP);
  assign data_thr_wr = thr_wr && !id_pending_ff && (!(master_node && dma_config_buffer_mode) || resp_phase_ff);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      thr_data_ff <= 8'h00;
      thr_full_ff <= 1'b0;
    end else if (data_thr_wr) begin
      thr_data_ff <= reg_wdata[7:0];
      thr_full_ff <= 1'b1;
    end else if (tx_start && !wake_pending_ff) begin
      thr_full_ff <= 1'b0;
    end
  end

  logic wake_cmd;

  assign wake_cmd = cr_wr && reg_wdata[ulw_pkg::CR_WAKE_REQUEST];
  assign tx_char = wake_pending_ff ? (wake_request_type ? ulw_pkg::WAKE_CHAR_V13
                                                        : ulw_pkg::WAKE_CHAR_V20)
                                   : thr_data_ff;
  // load on a bit tick so the start bit lasts a full period
  assign tx_start = bit_tick && !tx_busy && tx_enable && (wake_pending_ff || thr_full_ff);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wake_pending_ff <= 1'b0;
      wake_active_ff <= 1'b0;
    end else begin
      if (wake_cmd) begin
        wake_pending_ff <= 1'b1;
      end else if (tx_start && wake_pending_ff) begin
        wake_pending_ff <= 1'b0;
      end
      if (tx_start) begin
        wake_active_ff <= wake_pending_ff;
      end else if (!tx_busy) begin
        wake_active_ff <= 1'b0;
      end
    end
  end

  logic wake_done;
  assign wake_done = wake_active_ff && !tx_busy && !tx_start;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lin_transfer_complete_ff <= 1'b0;
    end else if (wake_done) begin
      lin_transfer_complete_ff <= 1'b1;
    end else if (cr_wr && reg_wdata[ulw_pkg::CR_STATUS_RESET]) begin
      lin_transfer_complete_ff <= 1'b0;
    end
  end

  // ************************************************************
  // test mode routing
  // ************************************************************
  logic rx_line;

  always_comb begin
    case (chmode)
      ulw_pkg::ULW_CH_NORMAL: rx_line = rxd_ff;
      ulw_pkg::ULW_CH_ECHO: rx_line = rxd_ff;
      ulw_pkg::ULW_CH_LOCAL_LOOP: rx_line = tx_line;
      default: rx_line = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      txd_pin <= 1'b1;
    end else begin
      case (chmode)
        ulw_pkg::ULW_CH_NORMAL: txd_pin <= tx_line;
        ulw_pkg::ULW_CH_ECHO: txd_pin <= rxd_ff;
        ulw_pkg::ULW_CH_LOCAL_LOOP: txd_pin <= 1'b1;
        default: txd_pin <= rxd_ff;
      endcase
    end
  end

  ulw_bit_shift u_shift (
    .clk_sys(clk_sys),
    .reset(reset),
    .bit_tick(bit_tick),
    .tx_enable(tx_enable),
    .tx_start(tx_start),
    .tx_char(tx_char),
    .tx_busy(tx_busy),
    .tx_line(tx_line),
    .rx_enable(rx_enable),
    .rx_line(rx_line),
    .rx_valid(rx_valid),
    .rx_char(rx_char)
  );

  // ************************************************************
  // receive holding and dma requests
  // ************************************************************
  logic [7:0] rhr_ff;
  logic rhr_full_ff;

  // in slave mode the first character after idle is the identifier, kept out of dma
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      id_wait_ff <= 1'b1;
    end else if (rx_valid) begin
      id_wait_ff <= 1'b0;
    end else if (timeout_flag_ff) begin
      id_wait_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rhr_ff <= 8'h00;
      rhr_full_ff <= 1'b0;
    end else if (rx_valid && !(!master_node && id_wait_ff)) begin
      rhr_ff <= rx_char;
      rhr_full_ff <= 1'b1;
    end else if (reg_rd && reg_addr == ulw_pkg::ADDR_RX_HOLD) begin
      rhr_full_ff <= 1'b0;
    end
  end

  assign dma_tx_req = !thr_full_ff && !wake_pending_ff;
  assign dma_rx_req = rhr_full_ff;

  // ************************************************************
  // bus idle timeout
  // ************************************************************
  logic [ulw_pkg::IDLE_WAIT_WIDTH-1:0] idle_cnt_ff;
  logic idle_run_ff;
  logic idle_armed_ff;
  logic arm_cmd;
  logic restart_cmd;
  logic to_enabled;

  assign arm_cmd = cr_wr && reg_wdata[ulw_pkg::CR_ARM_WAIT];
  assign restart_cmd = cr_wr && reg_wdata[ulw_pkg::CR_RESTART_WAIT];
  assign to_enabled = (idle_wait_reload_value_ff != '0);

  always_ff @(posedge clk_sys) begin
    if (reset || !to_enabled) begin
      idle_cnt_ff <= '0;
      idle_run_ff <= 1'b0;
      idle_armed_ff <= 1'b0;
    end else if (restart_cmd) begin
      idle_cnt_ff <= idle_wait_reload_value_ff;
      idle_run_ff <= 1'b1;
      idle_armed_ff <= 1'b0;
    end else if (arm_cmd) begin
      idle_run_ff <= 1'b0;
      idle_armed_ff <= 1'b1;
    end else if (rx_valid) begin
      idle_cnt_ff <= idle_wait_reload_value_ff;
      idle_run_ff <= 1'b1;
      idle_armed_ff <= 1'b0;
    end else if (idle_run_ff && bit_tick) begin
      if (idle_cnt_ff == 17'h0_0001 || idle_cnt_ff == '0) begin
        idle_cnt_ff <= '0;
        idle_run_ff <= 1'b0;
      end else begin
        idle_cnt_ff <= idle_cnt_ff - 17'h0_0001;
      end
    end
  end

  logic idle_expire;
  assign idle_expire = to_enabled && idle_run_ff && bit_tick && !restart_cmd && !arm_cmd && !rx_valid
                       && (idle_cnt_ff <= 17'h0_0001);

  always_ff @(posedge clk_sys) begin
    if (reset || !to_enabled) begin
      timeout_flag_ff <= 1'b0;
    end else if (idle_expire) begin
      timeout_flag_ff <= 1'b1;
    end else if (arm_cmd) begin
      timeout_flag_ff <= 1'b0;
    end
  end

  // ************************************************************
  // write protection
  // ************************************************************
  logic wpsr_rd;
  assign wpsr_rd = reg_rd && (reg_addr == ulw_pkg::ADDR_WP_STATUS);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      write_protect_enable_ff <= 1'b0;
    end else if (reg_wr && reg_addr == ulw_pkg::ADDR_WP_MODE && reg_wdata[31:8] == ulw_pkg::WP_KEY) begin
      write_protect_enable_ff <= reg_wdata[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      write_violation_flag_ff <= 1'b0;
      write_violation_source_ff <= 8'h00;
    end else if (reg_wr && write_protect_enable_ff && is_protected(reg_addr)) begin
      write_violation_flag_ff <= 1'b1;
      write_violation_source_ff <= reg_addr;
    end else if (wpsr_rd) begin
      write_violation_flag_ff <= 1'b0;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ulw_pkg::ADDR_MODE: reg_rdata <= mode_reg_ff;
        ulw_pkg::ADDR_CHAN_STATUS: begin
          reg_rdata <= '0;
          reg_rdata[ulw_pkg::SR_RXRDY] <= rhr_full_ff;
          reg_rdata[ulw_pkg::SR_TXRDY] <= dma_tx_req;
          reg_rdata[ulw_pkg::SR_TIMEOUT] <= timeout_flag_ff;
          reg_rdata[ulw_pkg::SR_LIN_TC] <= lin_transfer_complete_ff;
        end
        ulw_pkg::ADDR_RX_HOLD: reg_rdata <= {24'h00_0000, rhr_ff};
        ulw_pkg::ADDR_BAUD: reg_rdata <= baud_reg_ff;
        ulw_pkg::ADDR_IDLE_WAIT: reg_rdata <= {15'h0000, idle_wait_reload_value_ff};
        ulw_pkg::ADDR_TIMEGUARD: reg_rdata <= timeguard_reg_ff;
        ulw_pkg::ADDR_CLK_RATIO: reg_rdata <= ratio_reg_ff;
        ulw_pkg::ADDR_IR_FILTER: reg_rdata <= irfilter_reg_ff;
        ulw_pkg::ADDR_MANCHESTER: reg_rdata <= manchester_reg_ff;
        ulw_pkg::ADDR_LIN_MODE: reg_rdata <= lin_mode_reg_ff;
        ulw_pkg::ADDR_LIN_ID: reg_rdata <= {24'h00_0000, lin_identifier_reg_ff};
        ulw_pkg::ADDR_WP_MODE: reg_rdata <= {31'h0000_0000, write_protect_enable_ff};
        ulw_pkg::ADDR_WP_STATUS: reg_rdata <= {16'h0000, write_violation_source_ff, 7'h00, write_violation_flag_ff};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule
